// >>> design/lpm_pkg.sv
// package for the low-power mode controller: states, timing constants, source widths
// assumes a single 100 MHz clock domain
package lpm_pkg;

   localparam int CLK_MHZ          = 100;
   // stop wake time in ns, standby wake time in ns, clock step gap in ns
   localparam int STOP_WAKE_NS     = 3500;
   localparam int STBY_WAKE_NS     = 60000;
   localparam int STEP_GAP_NS      = 5000;
   localparam int CLK_PERIOD_NS    = 1000 / CLK_MHZ;
   // longest times round down, least times round up
   localparam int STOP_WAKE_CYC    = STOP_WAKE_NS / CLK_PERIOD_NS;
   localparam int STBY_WAKE_CYC    = STBY_WAKE_NS / CLK_PERIOD_NS;
   localparam int STEP_GAP_CYC     = (STEP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STEP_RATIO       = 4;

   localparam int GPIO_W           = 16;
   localparam int WAKE_PIN_W       = 3;
   localparam int FREQ_W           = 16;
   localparam int CNT_W            = 16;
   localparam int MODE_W           = 2;

   localparam logic [1:0] MODE_RUN      = 2'h0;
   localparam logic [1:0] MODE_STOP     = 2'h1;
   localparam logic [1:0] MODE_STBY_RTC = 2'h2;
   localparam logic [1:0] MODE_STBY     = 2'h3;

   typedef enum logic [4:0] {
      LPM_RUN      = 5'b0_0001,
      LPM_STOP     = 5'b0_0010,
      LPM_STOP_WK  = 5'b0_0100,
      LPM_STBY     = 5'b0_1000,
      LPM_STBY_WK  = 5'b1_0000
   } lpm_state_e;

endpackage : lpm_pkg

// >>> design/lpm_sync3.sv
// three-flop input synchroniser with agreement filter, vector wide
// assumes inputs come from outside the mclk_i domain
`timescale 1ns/10ps
module lpm_sync3 #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         mclk_i,
   input  wire logic         rst_n_i,
   // async in, filtered out
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= async_i;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // change counts only once the second and third flops agree
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_flt
         always_ff @(posedge mclk_i) begin
            if (!rst_n_i) begin
               sync_o[g] <= 1'b0;
            end else if (s2[g] == s3[g]) begin
               sync_o[g] <= s3[g];
            end
         end
      end
   endgenerate
endmodule // lpm_sync3

// >>> design/lpm_ctrl.sv
// low-power mode controller: stop / standby entry, gating, wakeup and clock-step guard
// assumes requests from core logic on mclk_i; wake sources from pins are asynchronous
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// - stop mode gates core clock, pll, multispeed and crystal fast oscillators
// - stop keeps ram and registers; core state is retained
// - in stop, a wake-capable peripheral may switch on the internal fast oscillator
// - stop puts core regulator in low-power state, not off
// - any external event line wakes stop; run resumes within 3.5 us
// - gpio, supply monitor, comparators (reference on) drive stop event lines
// - usb, usart, i2c, low-power serial and timer wakeups end stop
// - standby with rtc: regulator, core domain, pll, fast oscillators off; slow kept
// - standby loses core state; only standby-domain state is kept
// - standby with rtc ends within 60 us on reset, watchdog, pins or rtc events
// - standby without rtc: all oscillators off; only reset pin or wake pins end it
// - rtc, watchdog and their clocks are not stopped by stop or by standby with rtc
module lpm_ctrl (
   // clock and reset
   input  wire logic                     mclk_i,
   input  wire logic                     rst_n_i,
   // mode request from core
   input  wire logic                     enter_req_i,
   input  wire logic [lpm_pkg::MODE_W-1:0] enter_mode_i,
   // asynchronous wake sources
   input  wire logic [lpm_pkg::GPIO_W-1:0] ext_event_line_i,
   input  wire logic                     supply_monitor_out_i,
   input  wire logic [1:0]               comp_event_i,
   input  wire logic                     vref_on_i,
   input  wire logic [4:0]               periph_wake_i,
   input  wire logic                     periph_osc_req_i,
   input  wire logic [lpm_pkg::WAKE_PIN_W-1:0] wake_pin_i,
   input  wire logic                     ext_reset_pin_n_i,
   input  wire logic                     wdog_reset_i,
   input  wire logic [4:0]               rtc_event_i,
   // slow clock and watchdog enables, software owned
   input  wire logic                     slow_osc_en_i,
   input  wire logic                     wdog_en_i,
   // clock step request
   input  wire logic                     freq_step_i,
   input  wire logic [lpm_pkg::FREQ_W-1:0] freq_from_i,
   input  wire logic [lpm_pkg::FREQ_W-1:0] freq_to_i,
   // gating outputs
   output logic                          core_clk_en_o,
   output logic                          pll_en_o,
   output logic                          multispeed_osc_en_o,
   output logic                          internal_fast_osc_en_o,
   output logic                          crystal_fast_osc_en_o,
   output logic                          slow_osc_en_o,
   output logic                          regulator_on_o,
   output logic                          regulator_lp_o,
   output logic                          core_supply_domain_on_o,
   output logic                          core_reset_n_o,
   output logic                          retain_o,
   // status
   output logic [lpm_pkg::MODE_W-1:0]    mode_o,
   output logic                          wake_pulse_o,
   output logic                          step_err_o
);
   import lpm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // synchronisers: one bus, one filter, for every off-domain input
   localparam int SW = GPIO_W + 1 + 2 + 5 + WAKE_PIN_W + 1 + 1 + 5 + 1;
   logic [SW-1:0] raw_in;
   logic [SW-1:0] syn;
   assign raw_in = {ext_event_line_i, supply_monitor_out_i, comp_event_i, periph_wake_i,
                    wake_pin_i, ~ext_reset_pin_n_i, wdog_reset_i, rtc_event_i,
                    periph_osc_req_i};

   lpm_sync3 #(.W(SW)) u_sync (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .async_i (raw_in),
      .sync_o  (syn)
   );

   logic [GPIO_W-1:0]     s_ext;
   logic                  s_pvd;
   logic [1:0]            s_comp;
   logic [4:0]            s_per;
   logic [WAKE_PIN_W-1:0] s_pin;
   logic                  s_rst;
   logic                  s_wdg;
   logic [4:0]            s_rtc;
   logic                  s_oscreq;
   assign {s_ext, s_pvd, s_comp, s_per, s_pin, s_rst, s_wdg, s_rtc, s_oscreq} = syn;

   // rising edge on wake pins, from filtered values only
   logic [WAKE_PIN_W-1:0] pin_q;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         pin_q <= '0;
      end else begin
         pin_q <= s_pin;
      end
   end
   logic pin_rise;
   assign pin_rise = |(s_pin & ~pin_q);

   ////////////////////////////////////////////////////////////////////////////
   // wake decode
   logic stop_wake;
   logic stby_rtc_wake;
   logic stby_wake;
   assign stop_wake = (|s_ext) | s_pvd | ((|s_comp) & vref_on_i)
                    | (|s_per);
   assign stby_wake     = s_rst | pin_rise;
   assign stby_rtc_wake = stby_wake | s_wdg | (|s_rtc);

   ////////////////////////////////////////////////////////////////////////////
   // mode state machine
   lpm_state_e state;
   lpm_state_e next_state;
   logic [CNT_W-1:0] wcnt;
   logic             rtc_kept;

   always_comb begin
      next_state = state;
      unique case (state)
         LPM_RUN: begin
            if (enter_req_i && enter_mode_i == MODE_STOP) begin
               next_state = LPM_STOP;
            end else if (enter_req_i && enter_mode_i[1]) begin
               next_state = LPM_STBY;
            end
         end
         LPM_STOP: begin
            if (stop_wake) begin
               next_state = LPM_STOP_WK;
            end
         end
         LPM_STOP_WK: begin
            if (wcnt == CNT_W'(STOP_WAKE_CYC - 1)) begin
               next_state = LPM_RUN;
            end
         end
         LPM_STBY: begin
            if (rtc_kept ? stby_rtc_wake : stby_wake) begin
               next_state = LPM_STBY_WK;
            end
         end
         LPM_STBY_WK: begin
            if (wcnt == CNT_W'(STBY_WAKE_CYC - 1)) begin
               next_state = LPM_RUN;
            end
         end
         default: next_state = LPM_RUN;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state    <= LPM_RUN;
         wcnt     <= '0;
         rtc_kept <= 1'b0;
      end else begin
         state <= next_state;
         // wake latency count, cleared outside the wake states
         if (state == LPM_STOP_WK || state == LPM_STBY_WK) begin
            wcnt <= wcnt + CNT_W'(1);
         end else begin
            wcnt <= '0;
         end
         // standby flavour caught at entry
         if (state == LPM_RUN && enter_req_i && enter_mode_i[1]) begin
            rtc_kept <= (enter_mode_i == MODE_STBY_RTC);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // gating outputs
   logic in_stop;
   logic in_stby;
   assign in_stop = (next_state == LPM_STOP);
   assign in_stby = (next_state == LPM_STBY);
   function automatic logic rtc_kept_next();
      rtc_kept_next = (state == LPM_RUN) ? (enter_mode_i == MODE_STBY_RTC) : rtc_kept;
   endfunction

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         core_clk_en_o           <= 1'b1;
         pll_en_o                <= 1'b1;
         multispeed_osc_en_o     <= 1'b1;
         crystal_fast_osc_en_o   <= 1'b1;
         internal_fast_osc_en_o  <= 1'b1;
         slow_osc_en_o           <= 1'b0;
         regulator_on_o          <= 1'b1;
         regulator_lp_o          <= 1'b0;
         core_supply_domain_on_o <= 1'b1;
         retain_o                <= 1'b0;
         mode_o                  <= MODE_RUN;
         core_reset_n_o          <= 1'b0;
         wake_pulse_o            <= 1'b0;
      end else begin
         core_clk_en_o           <= !(in_stop || in_stby);
         pll_en_o                <= !(in_stop || in_stby);
         multispeed_osc_en_o     <= !(in_stop || in_stby);
         crystal_fast_osc_en_o   <= !(in_stop || in_stby);
         internal_fast_osc_en_o  <= in_stby ? 1'b0 :
                                    in_stop ? s_oscreq : 1'b1;
         // slow clocks stay with rtc/watchdog unless standby without rtc
         slow_osc_en_o           <= (slow_osc_en_i || wdog_en_i) &&
                                    !(in_stby && !rtc_kept_next());
         regulator_on_o          <= !in_stby;
         regulator_lp_o          <= in_stop;
         core_supply_domain_on_o <= !in_stby;
         retain_o                <= in_stop;
         mode_o                  <= in_stop ? MODE_STOP :
                                    in_stby ? (rtc_kept_next() ? MODE_STBY_RTC : MODE_STBY)
                                            : MODE_RUN;
         // core reset held from standby entry until wake completes
         core_reset_n_o          <= !(next_state == LPM_STBY ||
                                      next_state == LPM_STBY_WK);
         wake_pulse_o            <= (state == LPM_STOP_WK || state == LPM_STBY_WK) &&
                                    next_state == LPM_RUN;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock step guard: flags steps that break ratio or spacing
   logic [CNT_W-1:0] gap_cnt;
   logic             step_ok;
   assign step_ok = ({2'b00, freq_from_i} < (FREQ_W + 2)'(STEP_RATIO) * {2'b00, freq_to_i})
                    && gap_cnt == '0;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         gap_cnt <= '0;
      end else if (freq_step_i) begin
         gap_cnt <= CNT_W'(STEP_GAP_CYC - 1);
      end else if (gap_cnt != '0) begin
         gap_cnt <= gap_cnt - CNT_W'(1);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         step_err_o <= 1'b0;
      end else if (freq_step_i) begin
         step_err_o <= !step_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks, all on mclk_i and quiet during reset
   default clocking cb_chk @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   property p_stop_gate;
      (state == LPM_STOP) |-> !core_clk_en_o && !pll_en_o && regulator_lp_o && regulator_on_o;
   endproperty
   a_stop_gate: assert property (p_stop_gate) else $error("stop gating wrong");
   property p_retain;
      (state == LPM_STOP) |-> retain_o && core_reset_n_o;
   endproperty
   a_retain: assert property (p_retain) else $error("stop lost state");
   property p_reg_lp;
      $rose(state == LPM_STOP) |-> regulator_on_o && !core_supply_domain_on_o == 1'b0;
   endproperty
   a_reg_lp: assert property (p_reg_lp) else $error("regulator off in stop");
   property p_stop_wake;
      (state == LPM_STOP && stop_wake) |=> ##[0:350] state == LPM_RUN;
   endproperty
   a_stop_wake: assert property (p_stop_wake) else $error("stop wake too slow");
   property p_comp_gate;
      (state == LPM_STOP && !vref_on_i && s_ext == '0 && !s_pvd && s_per == '0)
      |=> state != LPM_STOP_WK;
   endproperty
   a_comp_gate: assert property (p_comp_gate) else $error("comparator woke without vref");
   property p_stby_off;
      (state == LPM_STBY) |-> !regulator_on_o && !core_supply_domain_on_o && !pll_en_o
                              && !internal_fast_osc_en_o && !core_reset_n_o;
   endproperty
   a_stby_off: assert property (p_stby_off) else $error("standby domain not off");
   property p_stby_wake;
      (state == LPM_STBY && s_rst) |=> state == LPM_STBY_WK;
   endproperty
   a_stby_wake: assert property (p_stby_wake) else $error("reset pin did not wake standby");
   // wake wait too long for a delay range, so bound the latency counter itself
   property p_stby_time;
      (state == LPM_STBY_WK) |-> wcnt < CNT_W'(STBY_WAKE_CYC);
   endproperty
   a_stby_time: assert property (p_stby_time) else $error("standby wake too slow");
   property p_norctc;
      (state == LPM_STBY && !rtc_kept) |-> !slow_osc_en_o;
   endproperty
   a_norctc: assert property (p_norctc) else $error("slow osc on without rtc");
   property p_rst_release;
      (state == LPM_STBY_WK && next_state == LPM_RUN) |=> core_reset_n_o;
   endproperty
   a_rst_release: assert property (p_rst_release) else $error("core not released");
endmodule // lpm_ctrl

// >>> sim/lpm_wake_model.sv
// wake-source model: asynchronous wake inputs and clock-step requests
// assumes callers enter its tasks just after a falling edge of mclk_i
`timescale 1ns/10ps
module lpm_wake_model
   import lpm_pkg::*;
(
   // clock
   input  wire logic                          mclk_i,
   // wake sources, all levels
   output logic [lpm_pkg::GPIO_W-1:0]         ext_event_line_o,
   output logic                               supply_monitor_out_o,
   output logic [1:0]                         comp_event_o,
   output logic [4:0]                         periph_wake_o,
   output logic [lpm_pkg::WAKE_PIN_W-1:0]     wake_pin_o,
   output logic                               ext_reset_pin_n_o,
   output logic                               wdog_reset_o,
   output logic [4:0]                         rtc_event_o,
   // clock step requests
   output logic                               freq_step_o,
   output logic [lpm_pkg::FREQ_W-1:0]         freq_from_o,
   output logic [lpm_pkg::FREQ_W-1:0]         freq_to_o
);
   initial begin
      {ext_event_line_o, supply_monitor_out_o, comp_event_o, periph_wake_o} = '0;
      {wake_pin_o, wdog_reset_o, rtc_event_o, freq_step_o} = '0;
      ext_reset_pin_n_o = 1'b1;
      freq_from_o = 16'h0000;
      freq_to_o = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // source codes: 0 line, 1 monitor, 2 comparator, 3-7 peripherals,
   // 8-10 wake pins, 11 reset pin, 12 watchdog, 13-17 rtc events
   task automatic src(input int k, input logic v);
      if (k == 0) ext_event_line_o[5] = v;
      else if (k == 1) supply_monitor_out_o = v;
      else if (k == 2) comp_event_o[1] = v;
      else if (k < 8) periph_wake_o[k-3] = v;
      else if (k < 11) wake_pin_o[k-8] = v;
      else if (k == 11) ext_reset_pin_n_o = ~v;
      else if (k == 12) wdog_reset_o = v;
      else rtc_event_o[k-13] = v;
   endtask

   // gap may be skipped only when a refusal is wanted
   task automatic step(input logic [FREQ_W-1:0] f, input logic [FREQ_W-1:0] t,
                       input logic gap);
      if (gap) repeat (STEP_GAP_CYC) @(negedge mclk_i);
      freq_from_o = f;
      freq_to_o = t;
      freq_step_o = 1'b1;
      @(negedge mclk_i);
      freq_step_o = 1'b0;
   endtask
endmodule // lpm_wake_model

// >>> sim/tb_top.sv
// testbench for lpm_ctrl: mode entry, gating, wake sources and timing, step monitor
// assumes 100 MHz clock; whole run is about 80k cycles
`timescale 1ns/10ps
module tb_top;
   import lpm_pkg::*;
   logic                  mclk_i = 1'b0;
   logic                  rst_n_i, enter_req, vref_on, osc_req, slow_en, wdog_en;
   logic [MODE_W-1:0]     enter_mode, mode;
   logic [GPIO_W-1:0]     ev_line;
   logic [1:0]            comp_ev;
   logic [4:0]            p_wake, rtc_ev;
   logic [WAKE_PIN_W-1:0] wpin;
   logic [FREQ_W-1:0]     f_from, f_to;
   logic                  sup_mon, ext_rst_n, wdog_rst, freq_step, wake_p, step_err;
   logic                  clk_en, pll_en, ms_en, if_en, cf_en, slow_o;
   logic                  reg_on, reg_lp, dom_on, crst_n, retain;
   int                    mismatches = 0;
   int                    cmp_count = 0;

   always #5 mclk_i = ~mclk_i;

   lpm_ctrl u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .enter_req_i(enter_req),
      .enter_mode_i(enter_mode), .ext_event_line_i(ev_line), .supply_monitor_out_i(sup_mon),
      .comp_event_i(comp_ev), .vref_on_i(vref_on), .periph_wake_i(p_wake),
      .periph_osc_req_i(osc_req), .wake_pin_i(wpin), .ext_reset_pin_n_i(ext_rst_n),
      .wdog_reset_i(wdog_rst), .rtc_event_i(rtc_ev), .slow_osc_en_i(slow_en),
      .wdog_en_i(wdog_en), .freq_step_i(freq_step), .freq_from_i(f_from), .freq_to_i(f_to),
      .core_clk_en_o(clk_en), .pll_en_o(pll_en), .multispeed_osc_en_o(ms_en),
      .internal_fast_osc_en_o(if_en), .crystal_fast_osc_en_o(cf_en), .slow_osc_en_o(slow_o),
      .regulator_on_o(reg_on), .regulator_lp_o(reg_lp), .core_supply_domain_on_o(dom_on),
      .core_reset_n_o(crst_n), .retain_o(retain), .mode_o(mode), .wake_pulse_o(wake_p),
      .step_err_o(step_err));

   lpm_wake_model u_part (.mclk_i(mclk_i), .ext_event_line_o(ev_line),
      .supply_monitor_out_o(sup_mon), .comp_event_o(comp_ev), .periph_wake_o(p_wake),
      .wake_pin_o(wpin), .ext_reset_pin_n_o(ext_rst_n), .wdog_reset_o(wdog_rst),
      .rtc_event_o(rtc_ev), .freq_step_o(freq_step), .freq_from_o(f_from), .freq_to_o(f_to));

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk_gate(input logic [1:0] m);
      logic run, lo;
      run = (m == MODE_RUN);
      lo = run || (m == MODE_STOP);
      chk("mode_o", m, mode);
      chk("core_clk_en_o", run, clk_en);
      chk("pll_en_o", run, pll_en);
      chk("multispeed_osc_en_o", run, ms_en);
      chk("crystal_fast_osc_en_o", run, cf_en);
      chk("internal_fast_osc_en_o", run | ((m == MODE_STOP) & osc_req), if_en);
      chk("slow_osc_en_o", (m != MODE_STBY) & (slow_en | wdog_en), slow_o);
      chk("regulator_on_o", lo, reg_on);
      chk("regulator_lp_o", m == MODE_STOP, reg_lp);
      chk("core_supply_domain_on_o", lo, dom_on);
      chk("core_reset_n_o", lo, crst_n);
      chk("retain_o", m == MODE_STOP, retain);
   endtask

   task automatic req(input logic [1:0] m);
      enter_req = 1'b1;
      enter_mode = m;
      @(negedge mclk_i);
      enter_req = 1'b0;
   endtask

   task automatic enter(input logic [1:0] m);
      req(m);
      chk_gate(m);
   endtask

   // pulse long enough to pass the input filter, then time the return to run
   task automatic wake(input int k, input int cyc);
      int n;
      n = 0;
      u_part.src(k, 1'b1);
      while (wake_p !== 1'b1 && n < 7000) begin
         @(negedge mclk_i);
         n++;
         if (n == 8) u_part.src(k, 1'b0);
      end
      u_part.src(k, 1'b0);
      chk("wake_cycles", 1'b1, n >= cyc && n <= cyc + 12);
      chk_gate(MODE_RUN);
      @(negedge mclk_i);
      chk("wake_pulse_o", 1'b0, wake_p);
   endtask

   task automatic quiet(input int k, input logic [1:0] m);
      u_part.src(k, 1'b1);
      repeat (8) @(negedge mclk_i);
      u_part.src(k, 1'b0);
      repeat (400) @(negedge mclk_i);
      chk_gate(m);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_stop;
      vref_on = 1'b1;
      for (int k = 0; k < 8; k++) begin
         osc_req = k[0];
         // request passes the input filter before stop is entered
         repeat (4) @(negedge mclk_i);
         enter(MODE_STOP);
         wake(k, STOP_WAKE_CYC);
      end
      $display("test stop_wake done");
   endtask

   task automatic t_stop_refuse;
      vref_on = 1'b0;
      enter(MODE_STOP);
      quiet(2, MODE_STOP);
      req(MODE_STBY);
      chk_gate(MODE_STOP);
      wake(1, STOP_WAKE_CYC);
      $display("test stop_refuse done");
   endtask

   task automatic t_stby_rtc;
      wdog_en = 1'b1;
      for (int k = 8; k < 18; k++) begin
         slow_en = k[0];
         enter(MODE_STBY_RTC);
         wake(k, STBY_WAKE_CYC);
      end
      $display("test standby_rtc done");
   endtask

   task automatic t_stby;
      slow_en = 1'b1;
      enter(MODE_STBY);
      quiet(13, MODE_STBY);
      quiet(12, MODE_STBY);
      wake(11, STBY_WAKE_CYC);
      enter(MODE_STBY);
      wake(9, STBY_WAKE_CYC);
      $display("test standby done");
   endtask

   task automatic stp(input logic [15:0] f, input logic [15:0] t, input logic g,
                      input logic e);
      u_part.step(f, t, g);
      @(negedge mclk_i);
      chk("step_err_o", e, step_err);
   endtask

   task automatic t_step;
      stp(16'h0010, 16'h0008, 1'b1, 1'b0);
      stp(16'h0028, 16'h000A, 1'b1, 1'b1);
      stp(16'h0027, 16'h000A, 1'b1, 1'b0);
      stp(16'h0008, 16'h0010, 1'b0, 1'b1);
      $display("test clock_step done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n_i = 1'b0;
      enter_req = 1'b0;
      enter_mode = MODE_RUN;
      {vref_on, osc_req, slow_en, wdog_en} = 4'h0;
      repeat (5) @(negedge mclk_i);
      rst_n_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      chk_gate(MODE_RUN);
      t_stop;
      t_stop_refuse;
      t_stby_rtc;
      t_stby;
      t_step;
      end_sim;
   end

   // hang guard, a little above the expected run length
   initial begin
      repeat (100000) @(posedge mclk_i);
      mismatches++;
      end_sim;
   end
endmodule // tb_top
